// [hdl/csi_pkg.sv]
// Purpose: shared constants and types for the stack and indirect address block
// Assumes: 8-bit data bus, 15-bit program counter, single core clock
// Notes:   register map covers the core-side control block only
package csi_pkg;
   localparam int             STACK_DEPTH      = 16;
   localparam int             PC_W             = 15;
   localparam int             PTR_W            = 5;
   localparam logic [4:0]     PTR_EMPTY        = 5'h1f;
   localparam logic [4:0]     PTR_TOP          = 5'h0f;
   localparam logic [4:0]     PTR_RESET        = 5'h1f;
   // register offsets on the software port
   localparam logic [7:0]     OFS_RETURN_PTR   = 8'h00;
   localparam logic [7:0]     OFS_TOP_LOW      = 8'h01;
   localparam logic [7:0]     OFS_TOP_HIGH     = 8'h02;
   localparam logic [7:0]     OFS_POWER_CTRL   = 8'h03;
   localparam logic [7:0]     OFS_PTR0_LOW     = 8'h04;
   localparam logic [7:0]     OFS_PTR0_HIGH    = 8'h05;
   localparam logic [7:0]     OFS_PTR1_LOW     = 8'h06;
   localparam logic [7:0]     OFS_PTR1_HIGH    = 8'h07;
   localparam logic [7:0]     OFS_CONFIGURATION_WORD_TWO_LO   = 8'h08;
   localparam logic [7:0]     OFS_CONFIGURATION_WORD_TWO_HI   = 8'h09;
   // power control field positions
   localparam int             PWR_OVER_BIT     = 7;
   localparam int             PWR_UNDER_BIT    = 6;
   // configuration word two
   localparam int             CFG2_W           = 14;
   localparam int             CFG2_FAULT_BIT   = 9;
   localparam logic [13:0]    CFG2_RESET       = 14'h3fff;
   localparam logic [15:0]    CFG2_ADDR        = 16'h8008;
   // indirect map
   localparam logic [15:0]    TRAD_LAST        = 16'h0fff;
   localparam logic [15:0]    LIN_FIRST        = 16'h2000;
   localparam logic [15:0]    LIN_LAST         = 16'h29af;
   localparam logic [6:0]     LIN_BLOCK        = 7'h50;
   localparam logic [6:0]     BANK_GPR_BASE    = 7'h20;
   localparam logic [11:0]    INDIRECT0_ADDR   = 12'h000;
   localparam logic [11:0]    INDIRECT1_ADDR   = 12'h001;
   localparam int             PROG_EXTRA_CYC   = 1;

   typedef enum logic [1:0] {
      CSI_REG_DATA, CSI_REG_LINEAR, CSI_REG_PROG, CSI_REG_NONE
   } csi_region_type;
endpackage

// [hdl/csi_if.sv]
// Purpose: carrier between the top and its two helpers
// Assumes: single clock domain
// Notes:   stack and decoder groups kept apart
`timescale 1ns/100ps
`default_nettype none
interface csi_stack_if;
   logic                 push;
   logic                 pop;
   logic [14:0]          push_pc;
   logic                 sw_ptr_we;
   logic [4:0]           sw_ptr_val;
   logic                 sw_low_we;
   logic                 sw_high_we;
   logic [7:0]           sw_data;
   logic [4:0]           ptr;
   logic [14:0]          top_entry;
   logic                 over_evt;
   logic                 under_evt;
   modport owner (input push, pop, push_pc, sw_ptr_we, sw_ptr_val, sw_low_we,
                  sw_high_we, sw_data, output ptr, top_entry, over_evt, under_evt);
   modport user  (output push, pop, push_pc, sw_ptr_we, sw_ptr_val, sw_low_we,
                  sw_high_we, sw_data, input ptr, top_entry, over_evt, under_evt);
endinterface

interface csi_dec_if;
   logic [15:0]          ptr;
   csi_pkg::csi_region_type region;
   logic [11:0]          data_addr;
   logic [14:0]          prog_addr;
   logic                 self_ref;
   modport owner (input ptr, output region, data_addr, prog_addr, self_ref);
   modport user  (output ptr, input region, data_addr, prog_addr, self_ref);
endinterface
`default_nettype wire

// [hdl/csi_stack.sv]
// Purpose: sixteen-entry return stack with five-bit pointer
// Assumes: push and pop never asserted together
// Notes:   circular wrap on overflow; fault handling done by the top
`timescale 1ns/100ps
`default_nettype none
module csi_stack (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   csi_stack_if.owner      sif
);
   typedef struct packed {
      logic [4:0]                         ptr;
      logic [csi_pkg::STACK_DEPTH-1:0][14:0] mem;
   } csi_stack_state_type;

   csi_stack_state_type st_r;
   csi_stack_state_type st_nxt;
   logic [3:0]             idx;
   logic [4:0]             inc_ptr;

   assign idx           = st_r.ptr[3:0];
   assign inc_ptr       = st_r.ptr + 5'h01;
   assign sif.ptr       = st_r.ptr;
   assign sif.top_entry = st_r.mem[idx];
   // overflow when full, underflow when empty
   assign sif.over_evt  = sif.push && (st_r.ptr == csi_pkg::PTR_TOP);
   assign sif.under_evt = sif.pop && (st_r.ptr == csi_pkg::PTR_EMPTY);

   always_comb begin
      st_nxt = st_r;
      if (sif.push) begin
         // increment first, then store at the new slot
         st_nxt.ptr = inc_ptr;
         // low four bits index the store, so slot 16 lands on slot 0
         st_nxt.mem[inc_ptr[3:0]] = sif.push_pc;
      end else if (sif.pop) begin
         // pc is taken from top_entry this cycle, then pointer drops
         st_nxt.ptr = st_r.ptr - 5'h01;
      end else if (sif.sw_ptr_we) begin
         st_nxt.ptr = sif.sw_ptr_val;
      end else if (sif.sw_low_we) begin
         st_nxt.mem[idx][7:0] = sif.sw_data;
      end else if (sif.sw_high_we) begin
         st_nxt.mem[idx][14:8] = sif.sw_data[6:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r.ptr <= csi_pkg::PTR_RESET;
         st_r.mem <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// [hdl/csi_decode.sv]
// Purpose: decode a 16-bit indirect pointer into a memory region and address
// Assumes: 80-byte general purpose block per bank starting at bank offset 0x20
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module csi_decode (
   csi_dec_if.owner        dif
);
   logic [15:0]            lin_off;
   logic [15:0]            bank;
   logic [15:0]            in_bank;

   assign lin_off = dif.ptr - csi_pkg::LIN_FIRST;
   assign bank    = lin_off / {9'h000, csi_pkg::LIN_BLOCK};
   assign in_bank = lin_off - bank * {9'h000, csi_pkg::LIN_BLOCK};
   assign dif.prog_addr = dif.ptr[14:0];
   assign dif.self_ref  = (dif.region == csi_pkg::CSI_REG_DATA) &&
                          ((dif.data_addr[6:0] == csi_pkg::INDIRECT0_ADDR[6:0]) ||
                           (dif.data_addr[6:0] == csi_pkg::INDIRECT1_ADDR[6:0]));

   always_comb begin
      dif.region    = csi_pkg::CSI_REG_NONE;
      dif.data_addr = 12'h000;
      if (dif.ptr[15]) begin
         dif.region = csi_pkg::CSI_REG_PROG;
      end else if (dif.ptr <= csi_pkg::TRAD_LAST) begin
         dif.region    = csi_pkg::CSI_REG_DATA;
         dif.data_addr = dif.ptr[11:0];
      end else if (dif.ptr >= csi_pkg::LIN_FIRST && dif.ptr <= csi_pkg::LIN_LAST) begin
         dif.region    = csi_pkg::CSI_REG_LINEAR;
         // bank base plus 0x20 skips specials; block ends before common ram
         dif.data_addr = {bank[4:0], 7'h00} + {5'h00, csi_pkg::BANK_GPR_BASE}
                         + {5'h00, in_bank[6:0]};
      end
   end
endmodule
`default_nettype wire

// [hdl/csi_core.sv]
// Purpose: return stack and indirect pointer block for the core
// Assumes: sequencer pulses push/pop one cycle; data bus is 8 bits, 12-bit address
// Notes:   program memory reads take one extra cycle; no writes reach program memory
//
// How it works
// - set return_pointer, then top_entry_high/low read and write the selected entry
// - return_pointer is five bits, readable and writable
// - calls, computed calls, interrupts push; three return kinds pop
// - push increments then stores; pop reads entry then decrements
// - empty pointer is 0x1F; first push gives 0x00
// - with fault reset enabled, overflow or underflow resets and sets its flag
// - fault reset enable is configuration word two bit 9
// - pointer at an indirect register reads zero, write dropped
// - pointer is high byte concatenated with low byte, 16 bits
// - pointer 0x000 to 0xFFF maps straight to data addresses
// - pointer 0x2000 to 0x29AF walks 80-byte ram blocks bank by bank
// - unimplemented linear locations read 0x00
// - common ram is never reached through linear addresses
// - pointer msb set selects program memory, low byte returned
// - indirect writes never modify program memory
// - program memory access through pointer costs one extra cycle
// - sixteen entries of fifteen bits, separate from memories
// - without fault reset the stack wraps and overwrites oldest entries
// - over and under flags set whether or not reset is enabled
`timescale 1ns/100ps
`default_nettype none
module csi_core (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // software register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // sequencer
   input  wire logic        call_push,
   input  wire logic        ret_pop,
   input  wire logic [14:0] pc_value,
   output logic [14:0]      ret_pc,
   output logic             fault_reset_req,
   // indirect access from the core
   input  wire logic        ind_sel,
   input  wire logic        ind_rd,
   input  wire logic        ind_wr,
   input  wire logic [7:0]  ind_wdata,
   output logic [7:0]       ind_rdata,
   output logic             ind_valid,
   // data memory side
   output logic [11:0]      dmem_addr,
   output logic             dmem_rd,
   output logic             dmem_wr,
   output logic [7:0]       dmem_wdata,
   input  wire logic [7:0]  dmem_rdata,
   input  wire logic        dmem_impl,
   // program memory side, read only
   output logic [14:0]      pmem_addr,
   output logic             pmem_rd,
   input  wire logic [13:0] pmem_rdata
);
   typedef enum logic [1:0] {CSI_IDLE, CSI_PROG_WAIT, CSI_DONE} csi_ind_state_type;

   typedef struct packed {
      logic [1:0][7:0]      ptr_low;
      logic [1:0][7:0]      ptr_high;
      logic                 over_flag;
      logic                 under_flag;
      logic [13:0]          cfg2;
      logic [7:0]           rdata;
      logic [7:0]           ind_data;
      logic                 ind_valid;
      csi_ind_state_type    ind_st;
      logic                 fault_req;
   } csi_core_state_type;

   csi_core_state_type st_r;
   csi_core_state_type st_nxt;

   csi_stack_if            sif ();
   csi_dec_if              dif ();

   logic [15:0]            ptr_sel;
   logic                   fault_en;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   csi_stack u_stack (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .sif     (sif)
   );

   csi_decode u_decode (
      .dif (dif)
   );

   assign ptr_sel  = {st_r.ptr_high[ind_sel], st_r.ptr_low[ind_sel]};
   assign dif.ptr  = ptr_sel;
   assign fault_en = st_r.cfg2[csi_pkg::CFG2_FAULT_BIT];

   assign sif.push       = call_push;
   assign sif.pop        = ret_pop;
   assign sif.push_pc    = pc_value;
   assign sif.sw_ptr_we  = reg_wr && hit(reg_addr, csi_pkg::OFS_RETURN_PTR);
   assign sif.sw_ptr_val = reg_wdata[4:0];
   assign sif.sw_low_we  = reg_wr && hit(reg_addr, csi_pkg::OFS_TOP_LOW);
   assign sif.sw_high_we = reg_wr && hit(reg_addr, csi_pkg::OFS_TOP_HIGH);
   assign sif.sw_data    = reg_wdata;
   // return pc is the entry under the pointer before it drops
   assign ret_pc          = sif.top_entry;

   assign reg_rdata       = st_r.rdata;
   assign fault_reset_req = st_r.fault_req;
   assign ind_rdata       = st_r.ind_data;
   assign ind_valid       = st_r.ind_valid;

   // data memory strobes are combinational so the answer lands next cycle
   assign dmem_addr  = dif.data_addr;
   assign dmem_wdata = ind_wdata;
   assign dmem_rd    = ind_rd && (st_r.ind_st == CSI_IDLE) &&
                       (dif.region == csi_pkg::CSI_REG_DATA ||
                        dif.region == csi_pkg::CSI_REG_LINEAR) && !dif.self_ref;
   assign dmem_wr    = ind_wr && (st_r.ind_st == CSI_IDLE) &&
                       (dif.region == csi_pkg::CSI_REG_DATA ||
                        dif.region == csi_pkg::CSI_REG_LINEAR) && !dif.self_ref;
   assign pmem_addr  = dif.prog_addr;
   // program memory has no write strobe at all
   assign pmem_rd    = ind_rd && (st_r.ind_st == CSI_IDLE) &&
                       (dif.region == csi_pkg::CSI_REG_PROG);

   always_comb begin
      st_nxt           = st_r;
      st_nxt.rdata     = 8'h00;
      st_nxt.ind_valid = 1'b0;
      st_nxt.fault_req = 1'b0;

      // flags set even with reset disabled; set wins over software clear
      if (reg_wr && hit(reg_addr, csi_pkg::OFS_POWER_CTRL)) begin
         st_nxt.over_flag  = reg_wdata[csi_pkg::PWR_OVER_BIT];
         st_nxt.under_flag = reg_wdata[csi_pkg::PWR_UNDER_BIT];
      end
      if (sif.over_evt) begin
         st_nxt.over_flag = 1'b1;
      end
      if (sif.under_evt) begin
         st_nxt.under_flag = 1'b1;
      end
      // reset request only when the option is programmed
      st_nxt.fault_req = fault_en && (sif.over_evt || sif.under_evt);

      if (reg_wr) begin
         if (hit(reg_addr, csi_pkg::OFS_PTR0_LOW)) begin
            st_nxt.ptr_low[0] = reg_wdata;
         end else if (hit(reg_addr, csi_pkg::OFS_PTR0_HIGH)) begin
            st_nxt.ptr_high[0] = reg_wdata;
         end else if (hit(reg_addr, csi_pkg::OFS_PTR1_LOW)) begin
            st_nxt.ptr_low[1] = reg_wdata;
         end else if (hit(reg_addr, csi_pkg::OFS_PTR1_HIGH)) begin
            st_nxt.ptr_high[1] = reg_wdata;
         end
      end

      if (reg_rd) begin
         if (hit(reg_addr, csi_pkg::OFS_RETURN_PTR)) begin
            st_nxt.rdata = {3'h0, sif.ptr};
         end else if (hit(reg_addr, csi_pkg::OFS_TOP_LOW)) begin
            st_nxt.rdata = sif.top_entry[7:0];
         end else if (hit(reg_addr, csi_pkg::OFS_TOP_HIGH)) begin
            st_nxt.rdata = {1'b0, sif.top_entry[14:8]};
         end else if (hit(reg_addr, csi_pkg::OFS_POWER_CTRL)) begin
            st_nxt.rdata[csi_pkg::PWR_OVER_BIT]  = st_r.over_flag;
            st_nxt.rdata[csi_pkg::PWR_UNDER_BIT] = st_r.under_flag;
         end else if (hit(reg_addr, csi_pkg::OFS_PTR0_LOW)) begin
            st_nxt.rdata = st_r.ptr_low[0];
         end else if (hit(reg_addr, csi_pkg::OFS_PTR0_HIGH)) begin
            st_nxt.rdata = st_r.ptr_high[0];
         end else if (hit(reg_addr, csi_pkg::OFS_PTR1_LOW)) begin
            st_nxt.rdata = st_r.ptr_low[1];
         end else if (hit(reg_addr, csi_pkg::OFS_PTR1_HIGH)) begin
            st_nxt.rdata = st_r.ptr_high[1];
         end else if (hit(reg_addr, csi_pkg::OFS_CONFIGURATION_WORD_TWO_LO)) begin
            st_nxt.rdata = st_r.cfg2[7:0];
         end else if (hit(reg_addr, csi_pkg::OFS_CONFIGURATION_WORD_TWO_HI)) begin
            st_nxt.rdata = {2'b00, st_r.cfg2[13:8]};
         end
      end

      case (st_r.ind_st)
         CSI_IDLE: begin
            if (ind_rd || ind_wr) begin
               if (dif.region == csi_pkg::CSI_REG_PROG) begin
                  // flash needs an extra cycle before the byte is ready
                  st_nxt.ind_st = CSI_PROG_WAIT;
               end else begin
                  st_nxt.ind_st = CSI_DONE;
               end
            end
         end
         CSI_PROG_WAIT: begin
            st_nxt.ind_st = CSI_DONE;
         end
         CSI_DONE: begin
            st_nxt.ind_valid = 1'b1;
            st_nxt.ind_st    = CSI_IDLE;
            st_nxt.ind_data  = 8'h00;
            if (dif.region == csi_pkg::CSI_REG_PROG) begin
               st_nxt.ind_data = pmem_rdata[7:0];
            end else if (dif.self_ref) begin
               st_nxt.ind_data = 8'h00;
            end else if (dif.region != csi_pkg::CSI_REG_NONE && dmem_impl) begin
               st_nxt.ind_data = dmem_rdata;
            end
         end
         default: begin
            st_nxt.ind_st = CSI_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r.ptr_low    <= '0;
         st_r.ptr_high   <= '0;
         st_r.over_flag  <= 1'b0;
         st_r.under_flag <= 1'b0;
         st_r.cfg2       <= csi_pkg::CFG2_RESET;
         st_r.rdata      <= 8'h00;
         st_r.ind_data   <= 8'h00;
         st_r.ind_valid  <= 1'b0;
         st_r.ind_st     <= CSI_IDLE;
         st_r.fault_req  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// [dv/csi_core_properties.sv]
// Purpose: concurrent checks on the ports of the stack and indirect block
// Assumes: single clock, reset synchronous active low
// Notes:   bound into every instance of the core
`timescale 1ns/100ps
`default_nettype none
module csi_core_properties (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        call_push,
   input wire logic        ret_pop,
   input wire logic [14:0] pc_value,
   input wire logic [14:0] ret_pc,
   input wire logic        fault_reset_req,
   input wire logic        ind_wr,
   input wire logic [7:0]  ind_wdata,
   input wire logic [7:0]  ind_rdata,
   input wire logic        ind_valid,
   input wire logic [11:0] dmem_addr,
   input wire logic        dmem_rd,
   input wire logic        dmem_wr,
   input wire logic [7:0]  dmem_wdata,
   input wire logic [7:0]  dmem_rdata,
   input wire logic        dmem_impl,
   input wire logic        pmem_rd,
   input wire logic [13:0] pmem_rdata
);
   logic       self_ref;
   logic [7:0] prog_byte;
   assign self_ref  = dmem_addr[6:1] == 6'h00;
   assign prog_byte = pmem_rdata[7:0];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence data_done; ##2 ind_valid; endsequence
   sequence prog_done; ##3 ind_valid; endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its answer cycle");
   push_store_a: assert property (call_push |=> ret_pc == $past(pc_value))
      else $error("pushed value not on top");
   fault_cause_a: assert property (fault_reset_req |-> $past(call_push) || $past(ret_pop))
      else $error("fault request without stack event");
   data_lat_a: assert property (dmem_rd |-> data_done)
      else $error("data access answer late");
   prog_lat_a: assert property (pmem_rd |-> prog_done)
      else $error("program access answer not one cycle longer");
   prog_nowrite_a: assert property (pmem_rd |-> !dmem_wr && !dmem_rd)
      else $error("program access touched data side");
   wr_cause_a: assert property (dmem_wr |-> ind_wr && dmem_wdata == ind_wdata)
      else $error("data write without matching request");
   data_read_a: assert property (ind_valid && $past(dmem_rd, 2) && $past(dmem_impl)
      && !$past(self_ref, 2) |-> ind_rdata == $past(dmem_rdata))
      else $error("indirect read data wrong");
   unimpl_zero_a: assert property (ind_valid && $past(dmem_rd, 2) && !$past(dmem_impl)
      |-> ind_rdata == 8'h00)
      else $error("unimplemented location not zero");
   prog_byte_a: assert property (ind_valid && $past(pmem_rd, 3)
      |-> ind_rdata == $past(prog_byte))
      else $error("program read not low byte");
endmodule
bind csi_core csi_core_properties u_props (.*);
`default_nettype wire

// [dv/csi_mem_model.sv]
// Purpose: behavioural data and program memory behind the core
// Assumes: top data page is unimplemented
// Notes:   read data held four cycles, then toggles so stale data never matches
`timescale 1ns/100ps
`default_nettype none
module csi_mem_model (
   input  wire logic        ref_clk,
   input  wire logic [11:0] dmem_addr,
   input  wire logic        dmem_rd,
   input  wire logic        dmem_wr,
   input  wire logic [7:0]  dmem_wdata,
   output logic      [7:0]  dmem_rdata,
   output logic             dmem_impl,
   input  wire logic [14:0] pmem_addr,
   input  wire logic        pmem_rd,
   output logic      [13:0] pmem_rdata
);
   logic [7:0] mem [4096];
   logic [1:0] age = 2'h3;
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
   end
   always @(posedge ref_clk) begin
      if (dmem_wr) mem[dmem_addr] <= dmem_wdata;
      if (dmem_rd || pmem_rd) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
      if (dmem_rd) begin
         dmem_rdata <= mem[dmem_addr];
         dmem_impl <= dmem_addr[11:8] != 4'hf;
      end else if (age == 2'h3) begin
         dmem_rdata <= ~dmem_rdata;
         dmem_impl <= ~dmem_impl;
      end
      if (pmem_rd) pmem_rdata <= {~pmem_addr[5:0], pmem_addr[7:0] ^ 8'h3c};
      else if (age == 2'h3) pmem_rdata <= ~pmem_rdata;
   end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the return stack and indirect decoder
// Assumes: fault reset enable reads as set in configuration word two
// Notes:   memory content comes from the behavioural model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_n, reg_wr, reg_rd, call_push, ret_pop, ind_sel, ind_rd, ind_wr;
   logic        fault_reset_req, ind_valid, dmem_rd, dmem_wr, dmem_impl, pmem_rd;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, ind_wdata, ind_rdata, dmem_wdata, dmem_rdata;
   logic [14:0] pc_value, ret_pc, pmem_addr;
   logic [11:0] dmem_addr;
   logic [13:0] pmem_rdata;
   logic [14:0] stk [16];
   logic [15:0] corner [6] = '{16'h0000, 16'h0001, 16'h0fff, 16'h2050, 16'h29af, 16'hffff};
   int          error_cnt = 0;
   int          n_tests = 0;
   csi_core dut (.*);
   csi_mem_model u_mem (.*);
   always #4 ref_clk = ~ref_clk;
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(string what, logic [7:0] a, logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check(what, 16'(reg_rdata), 16'(e));
   endtask
   task automatic push(logic [14:0] pc);
      @(posedge ref_clk);
      pc_value <= pc;
      call_push <= 1'b1;
      @(posedge ref_clk);
      call_push <= 1'b0;
   endtask
   task automatic pop(output logic [14:0] pc);
      @(posedge ref_clk);
      ret_pop <= 1'b1;
      #1 pc = ret_pc;
      @(posedge ref_clk);
      ret_pop <= 1'b0;
   endtask
   // address held until the answer; strobe is a single-cycle pulse
   task automatic ind(logic w, logic [7:0] d, output logic [7:0] q, output int c,
                      output logic [11:0] a);
      @(posedge ref_clk);
      ind_wr <= w;
      ind_rd <= !w;
      ind_wdata <= d;
      #1 a = dmem_addr;
      c = 0;
      do begin
         @(posedge ref_clk);
         ind_rd <= 1'b0;
         ind_wr <= 1'b0;
         #1 c++;
      end while (ind_valid !== 1'b1 && c < 8);
      q = ind_rdata;
      check("ind_valid", 16'(ind_valid), 16'h1);
   endtask
   function automatic logic [11:0] lin_addr(logic [15:0] p);
      int o = int'(p) - 32'h2000;
      return 12'((o / 32'h50) * 32'h80 + 32'h20 + o % 32'h50);
   endfunction
   // -1 for anything that must read as zero
   function automatic int dat(logic [15:0] p);
      int a = -1;
      if (p <= 16'h0fff) a = int'(p);
      if (p >= 16'h2000 && p <= 16'h29af) a = int'(lin_addr(p));
      if (a[6:1] == 6'h00 || a[11:8] == 4'hf) a = -1;
      return a;
   endfunction
   function automatic logic [7:0] exp_rd(logic [15:0] p);
      if (p[15]) return p[7:0] ^ 8'h3c;
      return dat(p) < 0 ? 8'h00 : u_mem.mem[dat(p)];
   endfunction
   initial begin
      int i, k, c;
      logic [7:0] q, d, old;
      logic [14:0] v;
      logic [15:0] p;
      logic [11:0] a;
      logic w, s;
      {rst_n, reg_wr, reg_rd, call_push, ret_pop, ind_sel, ind_rd, ind_wr} = '0;
      {reg_addr, reg_wdata, ind_wdata, pc_value} = '0;
      i = $urandom(32'h14a4c368);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h1f);
      rchk("power_control_reg", csi_pkg::OFS_POWER_CTRL, 8'h00);
      wr(csi_pkg::OFS_CONFIGURATION_WORD_TWO_LO, 8'h00);
      rchk("cfg2_low", csi_pkg::OFS_CONFIGURATION_WORD_TWO_LO, 8'hff);
      rchk("cfg2_high", csi_pkg::OFS_CONFIGURATION_WORD_TWO_HI, 8'h3f);
      rchk("unmapped", 8'h0a, 8'h00);
      for (i = 0; i < 16; i++) begin
         stk[i] = 15'($urandom);
         push(stk[i]);
         if (i == 0) rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h00);
      end
      rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h0f);
      stk[9] = 15'h5a3c;
      wr(csi_pkg::OFS_RETURN_PTR, 8'h09);
      wr(csi_pkg::OFS_TOP_LOW, 8'h3c);
      wr(csi_pkg::OFS_TOP_HIGH, 8'h5a);
      for (i = 0; i < 16; i++) begin
         wr(csi_pkg::OFS_RETURN_PTR, 8'(i));
         rchk("top_entry_low", csi_pkg::OFS_TOP_LOW, stk[i][7:0]);
         rchk("top_entry_high", csi_pkg::OFS_TOP_HIGH, {1'b0, stk[i][14:8]});
      end
      for (i = 15; i >= 0; i--) begin
         pop(v);
         check("ret_pc", 16'(v), 16'(stk[i]));
      end
      rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h1f);
      pop(v);
      #1 check("fault_reset_req", 16'(fault_reset_req), 16'h1);
      rchk("power_control_reg", csi_pkg::OFS_POWER_CTRL, 8'h40);
      wr(csi_pkg::OFS_POWER_CTRL, 8'h00);
      wr(csi_pkg::OFS_RETURN_PTR, 8'h0f);
      push(15'h7fff);
      #1 check("fault_reset_req", 16'(fault_reset_req), 16'h1);
      rchk("power_control_reg", csi_pkg::OFS_POWER_CTRL, 8'h80);
      // the push past the top slot wraps onto slot zero
      rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h10);
      rchk("top_entry_low", csi_pkg::OFS_TOP_LOW, 8'hff);
      rchk("top_entry_high", csi_pkg::OFS_TOP_HIGH, 8'h7f);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("return_pointer", csi_pkg::OFS_RETURN_PTR, 8'h1f);
      for (i = 0; i < 60; i++) begin
         k = $urandom % 5;
         case (k)
            0: p = 16'($urandom % 32'h1000);
            1: p = 16'h2000 + 16'($urandom % 32'h9b0);
            2: p = 16'h8000 | 16'($urandom);
            3: p = i[0] ? 16'h1000 + 16'($urandom % 32'h1000)
                        : 16'h29b0 + 16'($urandom % 32'h5650);
            default: p = corner[i % 6];
         endcase
         // select kept locally: the driven copy only updates after this time step
         s = 1'($urandom);
         w = 1'($urandom);
         d = 8'($urandom);
         old = exp_rd(p);
         @(posedge ref_clk);
         ind_sel <= s;
         wr(s ? csi_pkg::OFS_PTR1_LOW : csi_pkg::OFS_PTR0_LOW, p[7:0]);
         wr(s ? csi_pkg::OFS_PTR1_HIGH : csi_pkg::OFS_PTR0_HIGH, p[15:8]);
         ind(w, d, q, c, a);
         if (w) begin
            ind(1'b0, 8'h00, q, c, a);
            check("readback", 16'(q), 16'(dat(p) >= 0 ? d : old));
         end else begin
            check("ind_rdata", 16'(q), 16'(old));
            check("ind_cycles", 16'(c), p[15] ? 16'h3 : 16'h2);
            if (k == 1) check("dmem_addr", 16'(a), 16'(lin_addr(p)));
         end
      end
      summarize();
   end
   initial begin
      #100us;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
